// *** rtl/adcc_defines.vh ***
/*
 header of constants for the converter control block: register offsets,
 field positions, reset values and timing counts.
 assumes a 100 MHz system clock and an 8-bit register port.
*/
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// register offsets on the plain register port
`define ADCC_ADDR_W 8
`define ADCC_OFF_CTRL 8'h1F
`define ADCC_OFF_RESULT 8'h1E
`define ADCC_OFF_STATUS 8'h20
`define ADCC_OFF_MASK 8'h21

// control register fields
`define ADCC_CLK_HI 7
`define ADCC_CLK_LO 6
`define ADCC_CH_HI 5
`define ADCC_CH_LO 3
`define ADCC_GO_BIT 2
`define ADCC_UNIMP_BIT 1
`define ADCC_PWR_BIT 0
`define ADCC_CTRL_RST 8'h00
`define ADCC_WR_MASK 8'hFD

// clock select codes
`define ADCC_CS_DIV2 2'h0
`define ADCC_CS_DIV8 2'h1
`define ADCC_CS_DIV32 2'h2
`define ADCC_CS_RC 2'h3

// oscillator divide ratios, in system clocks per conversion clock period
`define ADCC_DIV2 8'h02
`define ADCC_DIV8 8'h08
`define ADCC_DIV32 8'h20
// internal rc clock period, 4000 ns typical, at 10 ns per system clock
`define ADCC_RC_PERIOD_NS 4000
`define ADCC_CLK_PERIOD_NS 10
`define ADCC_RC_CYCLES (`ADCC_RC_PERIOD_NS / `ADCC_CLK_PERIOD_NS)
`define ADCC_PRE_W 9
// half of the rc period in system clocks, sized for the prescaler
`define ADCC_RC_HALF 9'h0C8

// conversion length in half conversion clock periods: 9.5 periods
`define ADCC_HALF_PERIODS 5'h13

// interrupt status bit positions
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_W 1

`endif

// *** rtl/adcc_sar_core.v ***
/*
 successive approximation sequencer: paces one conversion from start to done
 in 9.5 periods of the selected conversion clock.
 assumes the analog comparator answers within one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "adcc_defines.vh"

module adcc_sar_core (
	input wire clk_sys_i,
	input wire srst_i,
	input wire start_i,
	input wire abort_i,
	input wire half_tick_i,
	input wire comp_i,
	output wire [7:0] dac_code_o,
	output reg busy_o,
	output reg done_o,
	output reg [7:0] result_o
);

	reg [4:0] half_q;
	reg [7:0] trial_q;
	reg [7:0] bit_q;

	assign dac_code_o = trial_q | bit_q;

	always @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		if (srst_i || abort_i) begin
			busy_o <= 1'b0;
			half_q <= 5'h00;
			trial_q <= 8'h00;
			bit_q <= 8'h00;
			if (srst_i)
				result_o <= 8'h00;
		end else if (start_i && !busy_o) begin
			busy_o <= 1'b1;
			half_q <= 5'h00;
			trial_q <= 8'h00;
			bit_q <= 8'h80;
		end else if (busy_o && half_tick_i) begin
			half_q <= half_q + 5'h01;
			// decide one bit on every second half period from the second to the sixteenth
			if (half_q[0] && bit_q != 8'h00) begin
				if (comp_i)
					trial_q <= trial_q | bit_q;
				bit_q <= bit_q >> 1;
			end
			if (half_q == `ADCC_HALF_PERIODS - 5'h01) begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
				result_o <= trial_q;
			end
		end
	end

endmodule // adcc_sar_core

`default_nettype wire

// *** rtl/adcc_conv_ctrl.v ***
/*
 converter control register block: control register, result register,
 interrupt status and mask, clock divider and conversion sequencing.
 assumes a same-clock register master and a synchronous analog front end;
 the trigger and comparator pins are synchronised here.
*/
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "adcc_defines.vh"

// How it works
// - clock select picks osc/2, /8, /32, rc
// - go bit starts conversion, hardware clears it
// - bit one reads zero, writes ignored
// - control register resets to all zero
// - done loads result, clears go, sets flag
// - compare trigger sets go only when powered
// - conversion lasts nine and half periods

module adcc_conv_ctrl (
	input wire clk_sys_i,
	input wire srst_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire cmp_trigger_i,
	input wire comp_out_i,
	output reg [2:0] input_channel_select_o,
	output reg converter_power_on_o,
	output reg sample_hold_o,
	output reg [7:0] dac_code_o,
	output reg conversion_done_flag_o,
	output wire irq_o
);

	reg [1:0] conv_clock_select_q;
	reg [2:0] input_channel_select_q;
	reg go_q;
	reg converter_power_on_q;
	reg [7:0] conversion_result_q;
	reg [`ADCC_IRQ_W-1:0] irq_status_q;
	reg [`ADCC_IRQ_W-1:0] irq_mask_q;
	reg [1:0] trig_sync_q;
	reg [1:0] comp_sync_q;
	reg trig_prev_q;
	reg [`ADCC_PRE_W-1:0] pre_q;
	reg [`ADCC_PRE_W-1:0] half_len;
	wire half_tick;
	wire trig_rise;
	wire sar_busy;
	wire sar_done;
	wire [7:0] sar_result;
	wire [7:0] sar_dac;
	wire ctrl_wr;
	wire sw_start;
	wire [7:0] ctrl_rd;
	wire [7:0] ctrl_rst_val;
	wire sel_ctrl;
	wire sel_result;
	wire sel_status;
	wire sel_mask;
	wire sar_start;

	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign sel_ctrl = hit(addr_i, `ADCC_OFF_CTRL);
	assign sel_result = hit(addr_i, `ADCC_OFF_RESULT);
	assign sel_status = hit(addr_i, `ADCC_OFF_STATUS);
	assign sel_mask = hit(addr_i, `ADCC_OFF_MASK);
	assign ctrl_wr = wr_i && sel_ctrl;
	assign ctrl_rst_val = `ADCC_CTRL_RST;
	// the done cycle still shows the old go bit; it must not start a second run
	assign sar_start = go_q && !sar_done;
	assign trig_rise = trig_sync_q[1] && !trig_prev_q;
	// power must already be on; setting go with power in one write is not honoured
	assign sw_start = ctrl_wr && wdata_i[`ADCC_GO_BIT] && converter_power_on_q;
	assign ctrl_rd = {conv_clock_select_q, input_channel_select_q, go_q, 1'b0,
		converter_power_on_q};

	// half a conversion clock period, in system clocks
	// at divide by two the comparator round trip outlasts a bit period
	always @* begin
		case (conv_clock_select_q)
		`ADCC_CS_DIV2: half_len = {1'b0, `ADCC_DIV2 >> 1};
		`ADCC_CS_DIV8: half_len = {1'b0, `ADCC_DIV8 >> 1};
		`ADCC_CS_DIV32: half_len = {1'b0, `ADCC_DIV32 >> 1};
		default: half_len = `ADCC_RC_HALF;
		endcase
	end

	assign half_tick = (pre_q == half_len - 9'h001);

	always @(posedge clk_sys_i) begin
		if (srst_i || !sar_busy || half_tick)
			pre_q <= {`ADCC_PRE_W{1'b0}};
		else
			pre_q <= pre_q + 9'h001;
	end

	// pins from outside pass two flops first
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			trig_sync_q <= 2'h0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_sync_q <= {trig_sync_q[0], cmp_trigger_i};
			trig_prev_q <= trig_sync_q[1];
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i)
			comp_sync_q <= 2'h0;
		else
			comp_sync_q <= {comp_sync_q[0], comp_out_i};
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			conv_clock_select_q <= ctrl_rst_val[`ADCC_CLK_HI:`ADCC_CLK_LO];
			input_channel_select_q <= ctrl_rst_val[`ADCC_CH_HI:`ADCC_CH_LO];
			converter_power_on_q <= ctrl_rst_val[`ADCC_PWR_BIT];
		end else if (ctrl_wr) begin
			conv_clock_select_q <= wdata_i[`ADCC_CLK_HI:`ADCC_CLK_LO];
			input_channel_select_q <= wdata_i[`ADCC_CH_HI:`ADCC_CH_LO];
			converter_power_on_q <= wdata_i[`ADCC_PWR_BIT];
		end
	end

	// done clears go; a new start in the same cycle wins
	always @(posedge clk_sys_i) begin
		if (srst_i)
			go_q <= ctrl_rst_val[`ADCC_GO_BIT];
		else if (ctrl_wr && !wdata_i[`ADCC_PWR_BIT])
			go_q <= 1'b0;
		else if (sw_start)
			go_q <= 1'b1;
		else if (trig_rise && converter_power_on_q)
			go_q <= 1'b1;
		else if (sar_done)
			go_q <= 1'b0;
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			conversion_result_q <= 8'h00;
			irq_status_q <= {`ADCC_IRQ_W{1'b0}};
			irq_mask_q <= {`ADCC_IRQ_W{1'b0}};
		end else begin
			if (sar_done)
				conversion_result_q <= sar_result;
			if (wr_i && sel_mask)
				irq_mask_q <= wdata_i[`ADCC_IRQ_W-1:0];
			// set wins over write-one-to-clear
			if (sar_done)
				irq_status_q[`ADCC_IRQ_DONE] <= 1'b1;
			else if (wr_i && sel_status && wdata_i[`ADCC_IRQ_DONE])
				irq_status_q[`ADCC_IRQ_DONE] <= 1'b0;
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (sel_ctrl)
				rdata_o <= ctrl_rd;
			else if (sel_result)
				rdata_o <= conversion_result_q;
			else if (sel_status)
				rdata_o <= {7'h00, irq_status_q};
			else if (sel_mask)
				rdata_o <= {7'h00, irq_mask_q};
			else
				rdata_o <= 8'h00;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			input_channel_select_o <= 3'h0;
			converter_power_on_o <= 1'b0;
			sample_hold_o <= 1'b0;
			dac_code_o <= 8'h00;
			conversion_done_flag_o <= 1'b0;
		end else begin
			input_channel_select_o <= input_channel_select_q;
			converter_power_on_o <= converter_power_on_q;
			// hold capacitor is disconnected from the pin while converting
			sample_hold_o <= sar_busy;
			dac_code_o <= sar_dac;
			conversion_done_flag_o <= irq_status_q[`ADCC_IRQ_DONE];
		end
	end

	// level output; stays high until software clears the status bit or its mask bit
	assign irq_o = |(irq_status_q & irq_mask_q);

	adcc_sar_core u_sar (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.start_i(sar_start),
		.abort_i(!converter_power_on_q),
		.half_tick_i(half_tick),
		.comp_i(comp_sync_q[1]),
		.dac_code_o(sar_dac),
		.busy_o(sar_busy),
		.done_o(sar_done),
		.result_o(sar_result)
	);

endmodule // adcc_conv_ctrl

`default_nettype wire

// *** test/adcc_conv_chk.sv ***
/* port checker for adcc_conv_ctrl
 bound to every instance of the block */
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_chk (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [2:0] input_channel_select_o,
	input wire logic converter_power_on_o,
	input wire logic sample_hold_o,
	input wire logic conversion_done_flag_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	logic [11:0] len_q;
	always @(posedge clk_sys_i) begin
		len_q <= (srst_i || !sample_hold_o) ? 12'h000 : len_q + 12'h001;
	end
	property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	property p_bit1; rd_i && addr_i == 8'h1F |=> !rdata_o[1]; endproperty
	a_bit1: assert property (p_bit1) else $error("bit one read high");
	property p_rst;
		$past(srst_i) |-> rdata_o == 8'h00 && !converter_power_on_o && !sample_hold_o
			&& input_channel_select_o == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_pwr;
		wr_i && addr_i == 8'h1F |-> ##2 converter_power_on_o == $past(wdata_i[0], 2);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not written");
	property p_chan;
		wr_i && addr_i == 8'h1F |-> ##2 input_channel_select_o == $past(wdata_i[5:3], 2);
	endproperty
	a_chan: assert property (p_chan) else $error("channel not routed");
	property p_hold; sample_hold_o |-> $past(converter_power_on_o, 2); endproperty
	a_hold: assert property (p_hold) else $error("converting while off");
	property p_off; !converter_power_on_o [*3] |-> !sample_hold_o; endproperty
	a_off: assert property (p_off) else $error("start while off");
	property p_len;
		$fell(sample_hold_o) && converter_power_on_o |-> len_q >= 12'h012 && len_q <= 12'hEE2;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_done;
		$rose(conversion_done_flag_o) |-> $past(sample_hold_o) || $past(sample_hold_o, 2);
	endproperty
	a_done: assert property (p_done) else $error("flag without conversion");
	c_done: cover property ($rose(conversion_done_flag_o));
	c_irq: cover property (irq_o);
	c_long: cover property ($fell(sample_hold_o) && len_q > 12'h800);
endmodule // adcc_conv_chk
bind adcc_conv_ctrl adcc_conv_chk u_chk (.clk_sys_i, .srst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .input_channel_select_o, .converter_power_on_o, .sample_hold_o,
	.conversion_done_flag_o, .irq_o);
`default_nettype wire

// *** test/adcc_afe_model.sv ***
/* analog front end model: channel levels and comparator
 assumes the block's dac code, channel and power outputs */
`timescale 1ns/1ps
`default_nettype none
module adcc_afe_model (
	input wire logic clk_sys_i,
	input wire logic pwr_i,
	input wire logic [2:0] ch_i,
	input wire logic [7:0] dac_i,
	input wire logic [63:0] lvl_i,
	output logic comp_o
);
	// level sits half a step above its code, so a code equal to it compares high
	always @(posedge clk_sys_i) begin
		if (pwr_i)
			comp_o <= lvl_i[ch_i*8 +: 8] >= dac_i;
		else
			comp_o <= (comp_o !== 1'b1); // unpowered comparator gives no valid answer
	end
endmodule // adcc_afe_model
`default_nettype wire

// *** test/adc_conversion_control_test.sv ***
/* self-checking bench for adcc_conv_ctrl
 assumes the checker is bound and the front end model stands beside it */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_test;
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, trig = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, dac;
	logic [63:0] lvl = 64'h0;
	logic [2:0] chs;
	logic pwr, hold, comp, flag, irq;
	int err_count = 0, compares = 0, n;
	always #5 clk = ~clk;
	adcc_conv_ctrl dut (.clk_sys_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmp_trigger_i(trig), .comp_out_i(comp),
		.input_channel_select_o(chs), .converter_power_on_o(pwr), .sample_hold_o(hold),
		.dac_code_o(dac), .conversion_done_flag_o(flag), .irq_o(irq));
	adcc_afe_model afe (.clk_sys_i(clk), .pwr_i(pwr), .ch_i(chs), .dac_i(dac), .lvl_i(lvl),
		.comp_o(comp));
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, rd, addr, wdata} <= {2'b10, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		{wr, rd, addr} <= {2'b01, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task automatic pulse_and_wait(input int lim);
		@(posedge clk);
		trig <= 1'b1;
		for (n = 0; n < lim && flag !== 1'b1; n++) begin
			@(posedge clk);
			trig <= 1'b0;
			#1;
		end
	endtask
	function automatic int half(input logic [1:0] cs);
		return cs == 2'h3 ? 200 : (cs == 2'h2 ? 16 : (cs == 2'h1 ? 4 : 1));
	endfunction
	task automatic conv(input logic [1:0] cs, input logic [2:0] ch);
		wr_reg(8'h1F, {cs, ch, 3'b001});
		wr_reg(8'h1F, {cs, ch, 3'b101});
		for (n = 0; n < 5000 && flag !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("cycles_ok", 8'h01, 8'(n >= 19 * half(cs) && n <= 20 * half(cs) + 8));
		if (n >= 5000) wrap_up();
		chk("irq", 8'h01, {7'h0, irq});
		rd_reg(8'h1E, lvl[ch*8 +: 8]);
		rd_reg(8'h1F, {cs, ch, 3'b001});
		chk("channel", {5'h0, ch}, {5'h0, chs});
		wr_reg(8'h20, 8'h01);
		#1 chk("irq_clear", 8'h00, {7'h0, irq});
		repeat (4 * half(cs)) @(posedge clk);
		$display("conversion test cs %0d ch %0d done", cs, ch);
	endtask
	initial begin
		void'($urandom(32'h564E));
		lvl = {$urandom, $urandom};
		lvl[15:0] = 16'h00FF;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd_reg(8'h1F, 8'h00);
		rd_reg(8'h5A, 8'h00);
		wr_reg(8'h1F, 8'hFF);
		rd_reg(8'h1F, 8'hF9);
		$display("register tests done");
		wr_reg(8'h21, 8'h01);
		conv(2'h1, 3'h0);
		conv(2'h1, 3'h1);
		// divide by two is too fast for the comparator loop: full scale only
		for (int i = 0; i < 4; i++) conv(i[1:0], i == 0 ? 3'h0 : 3'($urandom));
		pulse_and_wait(4000);
		chk("trig_done", 8'h01, {7'h0, flag});
		if (flag !== 1'b1) wrap_up();
		wr_reg(8'h20, 8'h01);
		wr_reg(8'h1F, 8'h00);
		pulse_and_wait(40);
		chk("trig_off", 8'h00, {7'h0, hold | flag});
		wr_reg(8'h1F, 8'h81);
		wr_reg(8'h1F, 8'h85);
		repeat (20) @(posedge clk);
		wr_reg(8'h1F, 8'h80);
		rd_reg(8'h1F, 8'h80);
		chk("abort_hold", 8'h00, {7'h0, hold});
		$display("trigger and abort tests done");
		wrap_up();
	end
endmodule // adc_conversion_control_test
`default_nettype wire
